// File: verilog/tap_ctrl.sv
// boundary scan test access port: controller, instruction, bypass and identification registers
// What this block does
// RULE1: five dedicated test pins are provided: mode select, test clock, test reset, data in and data out.
// RULE2: with the bypass instruction a single flip-flop sits between data in and data out.
// RULE3: the external test instruction lets the boundary cells drive and observe the pins.
// RULE4: the sample instruction captures the present pin values without disturbing normal operation.
// RULE5: the sample instruction also lets shifted values be preloaded into the latched boundary outputs.
// RULE6: the clamp instruction selects the bypass path while the boundary cells keep driving the pins.
// RULE7: the identification instruction makes maker, part number and version available for shifting out.
// RULE8: the system keeps the controller in test-logic-reset whenever the device runs in functional mode.
// RULE9: entering test-logic-reset forces the instruction to identification, a functional instruction.
// RULE10: test reset low forces test-logic-reset at once, without the test clock.
// RULE11: a 32-bit identification register holds maker, part number and version fields.
// RULE12: with the identification instruction current, that register forms the path from data in to out.
// RULE13: the identification register loads its fixed code in capture-data-register, then shifts it out.
// RULE14: identification bit 31 is nearest data in and bit 0 nearest data out, so bit 0 leaves first.
// RULE15: the controller is the sixteen-state machine stepped by mode select on rising edges, data out on falling.
// RULE16: the code has bit 0 at one, an 11-bit maker, a 16-bit part number and a 4-bit version on top.
`timescale 1ns/100ps
module tap_ctrl (
    // system clock domain
    input  wire logic                          clk,
    input  wire logic                          rstn,
    // test port pins
    input  wire logic                          tck,
    input  wire logic                          trst_n,
    input  wire logic                          tms,
    input  wire logic                          tdi,
    output logic                               tdo,
    output logic                               tdo_oe,
    // functional pins under boundary scan
    input  wire logic [tap_pkg::SCAN_PINS-1:0] core_out,
    output logic      [tap_pkg::SCAN_PINS-1:0] pin_out,
    input  wire logic [tap_pkg::SCAN_PINS-1:0] pin_in,
    output logic      [tap_pkg::SCAN_PINS-1:0] core_in,
    // status in the system clock domain
    output logic                               scan_drive,
    output logic                               tap_in_reset
);

    localparam int N = tap_pkg::SCAN_PINS;

    // =====================================================================
    // controller state machine
    tap_pkg::tap_state_t state_q;
    tap_pkg::tap_state_t state_d;

    always_comb begin
        case (state_q)
            tap_pkg::ST_TLR:      state_d = tms ? tap_pkg::ST_TLR      : tap_pkg::ST_RTI;     // RULE15
            tap_pkg::ST_RTI:      state_d = tms ? tap_pkg::ST_SEL_DR   : tap_pkg::ST_RTI;
            tap_pkg::ST_SEL_DR:   state_d = tms ? tap_pkg::ST_SEL_IR   : tap_pkg::ST_CAP_DR;
            tap_pkg::ST_CAP_DR:   state_d = tms ? tap_pkg::ST_EXIT1_DR : tap_pkg::ST_SHIFT_DR;
            tap_pkg::ST_SHIFT_DR: state_d = tms ? tap_pkg::ST_EXIT1_DR : tap_pkg::ST_SHIFT_DR;
            tap_pkg::ST_EXIT1_DR: state_d = tms ? tap_pkg::ST_UPD_DR   : tap_pkg::ST_PAUSE_DR;
            tap_pkg::ST_PAUSE_DR: state_d = tms ? tap_pkg::ST_EXIT2_DR : tap_pkg::ST_PAUSE_DR;
            tap_pkg::ST_EXIT2_DR: state_d = tms ? tap_pkg::ST_UPD_DR   : tap_pkg::ST_SHIFT_DR;
            tap_pkg::ST_UPD_DR:   state_d = tms ? tap_pkg::ST_SEL_DR   : tap_pkg::ST_RTI;
            tap_pkg::ST_SEL_IR:   state_d = tms ? tap_pkg::ST_TLR      : tap_pkg::ST_CAP_IR;
            tap_pkg::ST_CAP_IR:   state_d = tms ? tap_pkg::ST_EXIT1_IR : tap_pkg::ST_SHIFT_IR;
            tap_pkg::ST_SHIFT_IR: state_d = tms ? tap_pkg::ST_EXIT1_IR : tap_pkg::ST_SHIFT_IR;
            tap_pkg::ST_EXIT1_IR: state_d = tms ? tap_pkg::ST_UPD_IR   : tap_pkg::ST_PAUSE_IR;
            tap_pkg::ST_PAUSE_IR: state_d = tms ? tap_pkg::ST_EXIT2_IR : tap_pkg::ST_PAUSE_IR;
            tap_pkg::ST_EXIT2_IR: state_d = tms ? tap_pkg::ST_UPD_IR   : tap_pkg::ST_SHIFT_IR;
            tap_pkg::ST_UPD_IR:   state_d = tms ? tap_pkg::ST_SEL_DR   : tap_pkg::ST_RTI;
            // an illegal code falls back to the safe state
            default:              state_d = tap_pkg::ST_TLR;
        endcase
    end

    // test reset acts without the test clock, which settles the power-up state
    always_ff @(posedge tck or negedge trst_n) begin
        if (!trst_n) begin
            state_q <= tap_pkg::ST_TLR;                                                         // RULE10
        end else begin
            state_q <= state_d;
        end
    end

    // =====================================================================
    // instruction decode
    logic [tap_pkg::IR_W-1:0] ir_q;
    logic [tap_pkg::IR_W-1:0] ir_d;
    logic [tap_pkg::IR_W-1:0] ir_sh_q;
    logic [tap_pkg::IR_W-1:0] ir_sh_d;
    logic                     sel_bsr;
    logic                     sel_id;
    logic                     sel_byp;
    logic                     drive_bsr;

    always_comb begin
        sel_bsr   = (ir_q == tap_pkg::INSTR_EXTEST) || (ir_q == tap_pkg::INSTR_SAMPLE);      // RULE3 RULE4
        sel_id    = (ir_q == tap_pkg::INSTR_IDCODE);                                          // RULE12
        // bypass, clamp and any unknown code take the one-bit path
        sel_byp   = !sel_bsr && !sel_id;                                                      // RULE2 RULE6
        drive_bsr = (ir_q == tap_pkg::INSTR_EXTEST) || (ir_q == tap_pkg::INSTR_CLAMP);       // RULE3 RULE6
    end

    always_comb begin
        ir_sh_d = ir_sh_q;
        ir_d    = ir_q;
        if (state_q == tap_pkg::ST_CAP_IR) begin
            ir_sh_d = tap_pkg::IR_CAPTURE;
        end else if (state_q == tap_pkg::ST_SHIFT_IR) begin
            ir_sh_d = {tdi, ir_sh_q[tap_pkg::IR_W-1:1]};
        end
        if (state_q == tap_pkg::ST_TLR) begin
            ir_d = tap_pkg::INSTR_IDCODE;                                                     // RULE9
        end else if (state_q == tap_pkg::ST_UPD_IR) begin
            ir_d = ir_sh_q;
        end
    end

    always_ff @(posedge tck or negedge trst_n) begin
        if (!trst_n) begin
            ir_sh_q <= tap_pkg::IR_CAPTURE;
            ir_q    <= tap_pkg::INSTR_IDCODE;                                                 // RULE9
        end else begin
            ir_sh_q <= ir_sh_d;
            ir_q    <= ir_d;
        end
    end

    // =====================================================================
    // bypass and identification data registers
    logic                     byp_q;
    logic                     byp_d;
    logic [tap_pkg::ID_W-1:0] id_q;
    logic [tap_pkg::ID_W-1:0] id_d;

    always_comb begin
        byp_d = byp_q;
        id_d  = id_q;
        if (state_q == tap_pkg::ST_CAP_DR) begin
            byp_d = 1'h0;
            if (sel_id) begin
                id_d = tap_pkg::ID_VALUE;                                                     // RULE7 RULE13 RULE16
            end
        end else if (state_q == tap_pkg::ST_SHIFT_DR) begin
            if (sel_byp) begin
                byp_d = tdi;                                                                  // RULE2
            end
            if (sel_id) begin
                id_d = {tdi, id_q[tap_pkg::ID_W-1:1]};                                        // RULE11 RULE14
            end
        end
    end

    always_ff @(posedge tck or negedge trst_n) begin
        if (!trst_n) begin
            byp_q <= 1'h0;
            id_q  <= tap_pkg::ID_VALUE;
        end else begin
            byp_q <= byp_d;
            id_q  <= id_d;
        end
    end

    // =====================================================================
    // boundary scan register and pin multiplexing
    logic [2*N-1:0]              cap_raw_sync;
    logic [tap_pkg::BSR_LEN-1:0] bsr_cap;
    logic [tap_pkg::BSR_LEN-1:0] bsr_upd;
    logic                        bsr_so;

    // core outputs live on clk and the pins are asynchronous, so both are synchronised to tck
    tap_sync2 #(.W(2*N)) u_cap_sync (
        .clk      (tck),
        .rstn     (trst_n),
        .async_in ({core_out, pin_in}),
        .sync_out (cap_raw_sync)
    );

    always_comb begin
        // output cells observe what the pins really carry, input cells the pin levels
        bsr_cap = {(drive_bsr ? bsr_upd[2*N-1:N] : cap_raw_sync[2*N-1:N]), cap_raw_sync[N-1:0]}; // RULE4
    end

    bsr_chain u_bsr (
        .tck      (tck),
        .trst_n   (trst_n),
        .capture  (sel_bsr && (state_q == tap_pkg::ST_CAP_DR)),
        .shift    (sel_bsr && (state_q == tap_pkg::ST_SHIFT_DR)),
        .update   (sel_bsr && (state_q == tap_pkg::ST_UPD_DR)),                               // RULE5
        .si       (tdi),
        .cap_data (bsr_cap),
        .so       (bsr_so),
        .upd_out  (bsr_upd)
    );

    always_comb begin
        pin_out = drive_bsr ? bsr_upd[2*N-1:N] : core_out;                                    // RULE3 RULE6
        core_in = pin_in;                                                                     // RULE4
    end

    // =====================================================================
    // serial output, launched on the falling edge
    logic tdo_q;
    logic tdo_d;
    logic tdo_oe_q;
    logic tdo_oe_d;

    always_comb begin
        tdo_d    = tdo_q;
        tdo_oe_d = 1'h0;
        if (state_q == tap_pkg::ST_SHIFT_IR) begin
            tdo_d    = ir_sh_q[0];
            tdo_oe_d = 1'h1;
        end else if (state_q == tap_pkg::ST_SHIFT_DR) begin
            tdo_oe_d = 1'h1;
            if (sel_id) begin
                tdo_d = id_q[0];                                                              // RULE12 RULE14
            end else if (sel_bsr) begin
                tdo_d = bsr_so;
            end else begin
                tdo_d = byp_q;                                                                // RULE2
            end
        end
    end

    always_ff @(negedge tck or negedge trst_n) begin
        if (!trst_n) begin
            tdo_q    <= 1'h0;
            tdo_oe_q <= 1'h0;
        end else begin
            tdo_q    <= tdo_d;                                                                // RULE15
            tdo_oe_q <= tdo_oe_d;
        end
    end

    // five dedicated pins: tck, tms, trst_n, tdi and this driven tdo
    assign tdo    = tdo_q;                                                                    // RULE1
    assign tdo_oe = tdo_oe_q;

    // =====================================================================
    // status toward the system clock domain
    logic       st_drive_q;
    logic       st_drive_d;
    logic       st_tlr_q;
    logic       st_tlr_d;
    logic [1:0] st_sync;

    always_comb begin
        st_drive_d = drive_bsr;
        st_tlr_d   = (state_d == tap_pkg::ST_TLR);
    end

    always_ff @(posedge tck or negedge trst_n) begin
        if (!trst_n) begin
            st_drive_q <= 1'h0;
            st_tlr_q   <= 1'h1;
        end else begin
            st_drive_q <= st_drive_d;
            st_tlr_q   <= st_tlr_d;
        end
    end

    // the system watches tap_in_reset to confirm the port stays parked in functional mode
    tap_sync2 #(.W(2)) u_st_sync (
        .clk      (clk),
        .rstn     (rstn),
        .async_in ({st_drive_q, st_tlr_q}),                                                   // RULE8
        .sync_out (st_sync)
    );

    assign scan_drive   = st_sync[1];
    assign tap_in_reset = st_sync[0];

    // =====================================================================
    // checks
    sequence s_tms_high5;
        tms [*5];
    endsequence

    sequence s_shift_id;
        (state_q == tap_pkg::ST_SHIFT_DR) && sel_id;
    endsequence

    sequence s_capture_id;
        (state_q == tap_pkg::ST_CAP_DR) && sel_id;
    endsequence

    a_tms_reset_walk: assert property (@(posedge tck) disable iff (!trst_n) // RULE15
        s_tms_high5 |=> (state_q == tap_pkg::ST_TLR))
        else $error("five tms ones did not reach test-logic-reset");

    // sampled on clk because tck stands still while test reset is held
    a_trst_forces_tlr: assert property (@(posedge clk) // RULE10
        !trst_n |-> (state_q == tap_pkg::ST_TLR) && (ir_q == tap_pkg::INSTR_IDCODE))
        else $error("test reset did not force reset state");

    a_tlr_ir_idcode: assert property (@(posedge tck) disable iff (!trst_n) // RULE9
        (state_q == tap_pkg::ST_TLR) |=> (ir_q == tap_pkg::INSTR_IDCODE))
        else $error("instruction not forced to identification in reset state");

    a_id_capture_code: assert property (@(posedge tck) disable iff (!trst_n) // RULE13
        s_capture_id |=> (id_q == tap_pkg::ID_VALUE) && id_q[0])
        else $error("identification code not captured");

    a_id_shift_order: assert property (@(posedge tck) disable iff (!trst_n) // RULE14
        s_shift_id |=> (id_q[tap_pkg::ID_W-1] == $past(tdi)) && (id_q[tap_pkg::ID_W-2:0] == $past(id_q[tap_pkg::ID_W-1:1])))
        else $error("identification register shifted the wrong way");

    a_id_tdo_lsb: assert property (@(negedge tck) disable iff (!trst_n) // RULE12
        s_shift_id |=> (tdo == $past(id_q[0])) && tdo_oe)
        else $error("tdo does not carry identification bit 0");

    a_bypass_one_bit: assert property (@(posedge tck) disable iff (!trst_n) // RULE2
        ((state_q == tap_pkg::ST_SHIFT_DR) && sel_byp) |=> (byp_q == $past(tdi)))
        else $error("bypass flip-flop did not take tdi");

    a_extest_pins: assert property (@(posedge tck) disable iff (!trst_n) // RULE3
        (ir_q == tap_pkg::INSTR_EXTEST) |-> (pin_out == bsr_upd[2*N-1:N]))
        else $error("pins not driven from boundary cells");

    a_clamp_bypass: assert property (@(posedge tck) disable iff (!trst_n) // RULE6
        (ir_q == tap_pkg::INSTR_CLAMP) |-> sel_byp && (pin_out == bsr_upd[2*N-1:N]))
        else $error("clamp does not hold pins with bypass selected");

    a_sample_transparent: assert property (@(posedge tck) disable iff (!trst_n) // RULE4
        (ir_q == tap_pkg::INSTR_SAMPLE) |-> (pin_out == core_out) && (core_in == pin_in))
        else $error("sample disturbed the functional pins");

    a_preload_update: assert property (@(posedge tck) disable iff (!trst_n) // RULE5
        ((state_q == tap_pkg::ST_UPD_DR) && sel_bsr) |=> (bsr_upd == $past(u_bsr.sh_q)))
        else $error("boundary preload not latched on update");

endmodule : tap_ctrl

// File: verilog/tap_pkg.sv
// constants, instruction codes and controller states of the boundary scan port
package tap_pkg;

    // =====================================================================
    // register widths
    localparam int IR_W      = 4;
    localparam int ID_W      = 32;
    localparam int SCAN_PINS = 8;
    localparam int BSR_LEN   = 2 * SCAN_PINS;

    // =====================================================================
    // instruction codes
    localparam logic [IR_W-1:0] INSTR_EXTEST = 4'h0;
    localparam logic [IR_W-1:0] INSTR_SAMPLE = 4'h1;
    localparam logic [IR_W-1:0] INSTR_IDCODE = 4'h2;
    localparam logic [IR_W-1:0] INSTR_CLAMP  = 4'h3;
    localparam logic [IR_W-1:0] INSTR_BYPASS = 4'hf;
    // fixed pattern captured into the instruction shifter, low bits 01
    localparam logic [IR_W-1:0] IR_CAPTURE   = 4'h1;

    // =====================================================================
    // identification code fields; field values are arbitrary
    localparam int              ID_MARK_POS  = 0;
    localparam int              ID_MAKER_POS = 1;
    localparam int              ID_PART_POS  = 12;
    localparam int              ID_VER_POS   = 28;
    localparam logic [10:0]     ID_MAKER     = 11'h02a;
    localparam logic [15:0]     ID_PART      = 16'h0c35;
    localparam logic [3:0]      ID_VER       = 4'h1;
    localparam logic            ID_MARK      = 1'h1;
    localparam logic [ID_W-1:0] ID_VALUE     = {ID_VER, ID_PART, ID_MAKER, ID_MARK};

    // =====================================================================
    // controller states, one-hot
    typedef enum logic [15:0] {
        ST_TLR       = 16'h0001,
        ST_RTI       = 16'h0002,
        ST_SEL_DR    = 16'h0004,
        ST_CAP_DR    = 16'h0008,
        ST_SHIFT_DR  = 16'h0010,
        ST_EXIT1_DR  = 16'h0020,
        ST_PAUSE_DR  = 16'h0040,
        ST_EXIT2_DR  = 16'h0080,
        ST_UPD_DR    = 16'h0100,
        ST_SEL_IR    = 16'h0200,
        ST_CAP_IR    = 16'h0400,
        ST_SHIFT_IR  = 16'h0800,
        ST_EXIT1_IR  = 16'h1000,
        ST_PAUSE_IR  = 16'h2000,
        ST_EXIT2_IR  = 16'h4000,
        ST_UPD_IR    = 16'h8000
    } tap_state_t;

endpackage : tap_pkg

// File: verilog/tap_sync2.sv
// two flip-flop level synchroniser
`timescale 1ns/100ps
module tap_sync2 #(
    parameter int W = 1
) (
    // clock and reset of the receiving domain
    input  wire logic         clk,
    input  wire logic         rstn,
    // levels in and out
    input  wire logic [W-1:0] async_in,
    output logic      [W-1:0] sync_out
);

    logic [W-1:0] meta_q;
    logic [W-1:0] meta_d;
    logic [W-1:0] sync_q;
    logic [W-1:0] sync_d;

    always_comb begin
        meta_d = async_in;
        sync_d = meta_q;
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            meta_q <= '0;
            sync_q <= '0;
        end else begin
            meta_q <= meta_d;
            sync_q <= sync_d;
        end
    end

    assign sync_out = sync_q;

endmodule : tap_sync2

// File: verilog/bsr_chain.sv
// boundary scan register: capture/shift stage and latched update stage
`timescale 1ns/100ps
module bsr_chain (
    // test clock and test reset
    input  wire logic                        tck,
    input  wire logic                        trst_n,
    // controls from the controller
    input  wire logic                        capture,
    input  wire logic                        shift,
    input  wire logic                        update,
    // serial and parallel data
    input  wire logic                        si,
    input  wire logic [tap_pkg::BSR_LEN-1:0] cap_data,
    output logic                             so,
    output logic      [tap_pkg::BSR_LEN-1:0] upd_out
);

    logic [tap_pkg::BSR_LEN-1:0] sh_q;
    logic [tap_pkg::BSR_LEN-1:0] sh_d;
    logic [tap_pkg::BSR_LEN-1:0] upd_q;
    logic [tap_pkg::BSR_LEN-1:0] upd_d;

    always_comb begin
        sh_d  = sh_q;
        upd_d = upd_q;
        if (capture) begin
            sh_d = cap_data;
        end else if (shift) begin
            sh_d = {si, sh_q[tap_pkg::BSR_LEN-1:1]};
        end
        // the latched stage only moves on update, so shifting never disturbs the pins
        if (update) begin
            upd_d = sh_q;
        end
    end

    always_ff @(posedge tck or negedge trst_n) begin
        if (!trst_n) begin
            sh_q  <= '0;
            upd_q <= '0;
        end else begin
            sh_q  <= sh_d;
            upd_q <= upd_d;
        end
    end

    assign so      = sh_q[0];
    assign upd_out = upd_q;

endmodule : bsr_chain

// File: bench/jtag_host.sv
// board test controller model that drives the test port
`timescale 1ns/100ps
module jtag_host (
    // test port toward the device
    output logic      tck,
    output logic      trst_n,
    output logic      tms,
    output logic      tdi,
    input  wire logic tdo
);
    initial begin
        tck = 1'b0;
        // starts high so that the first reset pulse gives the device a real falling edge
        trst_n = 1'b1;
        tms = 1'b1;
        tdi = 1'b0;
    end

    // =====================================================================
    // one tck period; tck rests low between frames, tdo taken before the rise
    task automatic step(input logic m, input logic d, output logic o);
        tms = m;
        tdi = d;
        #32 o = tdo;
        tck = 1'b1;
        #32 tck = 1'b0;
    endtask : step

    // =====================================================================
    // test reset pulse, then five ones to park in test-logic-reset
    task automatic hard_reset();
        logic o;
        trst_n = 1'b0;
        #150 trst_n = 1'b1;
        for (int i = 0; i < 5; i++) step(1'b1, ~tdi, o);
    endtask : hard_reset

    // =====================================================================
    // idle, capture, shift n bits lsb first, update, idle; tdi toggles when unused
    task automatic scan(input logic ir, input int n, input logic [31:0] din, output logic [31:0] dout);
        logic o;
        dout = '0;
        step(1'b0, ~tdi, o);
        step(1'b1, ~tdi, o);
        if (ir) step(1'b1, ~tdi, o);
        step(1'b0, ~tdi, o);
        step(1'b0, ~tdi, o);
        for (int i = 0; i < n; i++) begin
            step(i == n - 1, din[i], o);
            dout[i] = o;
        end
        step(1'b1, ~tdi, o);
        step(1'b0, ~tdi, o);
        step(1'b0, ~tdi, o);
    endtask : scan
endmodule : jtag_host

// File: bench/test_tap_ctrl.sv
// self-checking bench for the boundary scan test port
`timescale 1ns/100ps
module test_tap_ctrl;
    logic       clk, rstn, tck, trst_n, tms, tdi, tdo, tdo_oe, scan_drive, tap_in_reset;
    logic [7:0] core_out, pin_out, pin_in, core_in;
    logic [31:0] got, pre, r;
    int         n_fail, comparisons, cycles;

    tap_ctrl i_dut (.clk(clk), .rstn(rstn), .tck(tck), .trst_n(trst_n), .tms(tms), .tdi(tdi), .tdo(tdo),
        .tdo_oe(tdo_oe), .core_out(core_out), .pin_out(pin_out), .pin_in(pin_in), .core_in(core_in),
        .scan_drive(scan_drive), .tap_in_reset(tap_in_reset));
    jtag_host i_host (.tck(tck), .trst_n(trst_n), .tms(tms), .tdi(tdi), .tdo(tdo));

    initial clk = 1'b0;
    always #10 clk = ~clk;

    // =====================================================================
    // checking and closing
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] seen);
        comparisons++;
        if (seen !== exp) begin
            n_fail++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic give_verdict();
        $display("comparisons %0d n_fail %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : give_verdict

    // the whole run needs under a thousand clk cycles
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            n_fail++;
            give_verdict();
        end
    end

    // =====================================================================
    // expectations and helpers
    function automatic logic [31:0] id_expect();
        return {tap_pkg::ID_VER, tap_pkg::ID_PART, tap_pkg::ID_MAKER, 1'b1};
    endfunction : id_expect

    task automatic settle();
        repeat (4) @(posedge clk);
    endtask : settle

    task automatic drive_pins();
        @(posedge clk);
        r = $urandom;
        core_out <= r[7:0];
        pin_in <= r[15:8];
        repeat (3) @(posedge clk);
    endtask : drive_pins

    task automatic load(input logic [3:0] code);
        i_host.scan(1'b1, 4, 32'(code), got);
        check("ir capture", 32'(tap_pkg::IR_CAPTURE), got);
    endtask : load

    // =====================================================================
    // main sequence
    initial begin
        logic [3:0] codes [2];
        codes = '{tap_pkg::INSTR_BYPASS, 4'h7};
        rstn = 1'b0;
        core_out = 8'h00;
        pin_in = 8'h00;
        r = $urandom(60);
        repeat (3) @(posedge clk);
        rstn <= 1'b1;
        drive_pins();
        i_host.hard_reset();
        settle();
        check("in reset", 32'h1, 32'(tap_in_reset));
        check("pins functional", 32'(core_out), 32'(pin_out));
        i_host.scan(1'b0, 32, $urandom, got);
        check("idcode", id_expect(), got);
        settle();
        check("left reset", 32'h0, 32'(tap_in_reset));
        check("drive off", 32'h0, 32'(tdo_oe));
        foreach (codes[k]) begin
            load(codes[k]);
            r = $urandom;
            i_host.scan(1'b0, 8, r, got);
            check("bypass path", 32'({r[6:0], 1'b0}), got);
            check("pins functional", 32'(core_out), 32'(pin_out));
        end
        drive_pins();
        load(tap_pkg::INSTR_SAMPLE);
        pre = $urandom;
        i_host.scan(1'b0, 16, pre, got);
        check("sample capture", 32'({core_out, pin_in}), got);
        settle();
        check("sample pins", 32'(core_out), 32'(pin_out));
        check("sample core_in", 32'(pin_in), 32'(core_in));
        check("sample drive", 32'h0, 32'(scan_drive));
        load(tap_pkg::INSTR_EXTEST);
        settle();
        check("preload out", 32'(pre[15:8]), 32'(pin_out));
        check("extest drive", 32'h1, 32'(scan_drive));
        drive_pins();
        i_host.scan(1'b0, 16, pre, got);
        check("extest capture", 32'(pin_in), 32'(got[7:0]));
        check("extest out cells", 32'(pre[15:8]), 32'(got[15:8]));
        load(tap_pkg::INSTR_CLAMP);
        settle();
        check("clamp out", 32'(pre[15:8]), 32'(pin_out));
        check("clamp drive", 32'h1, 32'(scan_drive));
        r = $urandom;
        i_host.scan(1'b0, 8, r, got);
        check("clamp bypass", 32'({r[6:0], 1'b0}), got);
        i_host.hard_reset();
        settle();
        check("reset pins", 32'(core_out), 32'(pin_out));
        check("reset drive", 32'h0, 32'(scan_drive));
        i_host.scan(1'b0, 32, $urandom, got);
        check("idcode after reset", id_expect(), got);
        give_verdict();
    end
endmodule : test_tap_ctrl
